// file: design/ssb_top.sv
// Buffered synchronous serial port with APB register access.
// Assumes one pclk domain; serial pins synchronous to pclk.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module ssb_top
   import ssb_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic slow_mode,
   input wire logic lf_clk,
   input wire logic si_i,
   output logic so_o,
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe,
   output logic transfer_irq
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [7:0] buf_ff [BUF_DEPTH];
   logic run_ff, abort_ff, tap_ff, active_ff, nxt_active, sck_ff, nxt_sck, so_ff, nxt_so;
   logic irq_ff, nxt_irq, abort_done, rx_store, half_tick, ext_fall, ext_rise;
   logic [2:0] mode_ff, clksel_ff, cnt_ff, word_ff, nxt_word, bit_ff, nxt_bit;
   logic [1:0] wait_ff;
   ssb_state_t state_ff, nxt_state;
   logic [7:0] tx_sh_ff, nxt_tx_sh, rx_sh_ff, nxt_rx_sh, rx_word, rx_full;
   logic [6:0] frame_ff, nxt_frame;
   logic [31:0] prdata_ff;

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   wire setup = psel & ~penable;
   wire access = psel & penable;
   wire wr = access & pwrite;
   wire [11:0] word_a = paddr[13:2];
   wire aligned = (paddr[1:0] == 2'h0) && (paddr[15:14] == 2'h0);
   wire hit_buf = aligned && (word_a[11:3] == IDX_BUF_BASE[11:3]);
   wire hit_c1 = aligned && (word_a == IDX_CTRL1);
   wire hit_c2 = aligned && (word_a == IDX_CTRL2);
   wire hit_st = aligned && (word_a == IDX_STAT);
   wire mapped = hit_buf | hit_c1 | hit_c2 | hit_st;
   wire [2:0] buf_sel = word_a[2:0];
   wire wr_c1 = wr & hit_c1;
   wire wr_c2 = wr & hit_c2;
   wire [7:0] status = {active_ff, state_ff == ST_SHIFT, 6'h00};
   // Control registers are write-only and read as zero
   wire [31:0] rd_mux = hit_buf ? {24'h0000_00, buf_ff[buf_sel]} :
                        hit_st ? {24'h0000_00, status} : 32'h0000_0000;

   assign pready = 1'b1;
   assign pslverr = access & ~mapped;
   assign prdata = prdata_ff;

   // ----------------------------------------
   // Mode and clock qualifiers
   // ----------------------------------------
   // mode decode
   wire mode_ok = (mode_ff == MODE_TX8) || (mode_ff == MODE_TX4) || (mode_ff == MODE_TRX8) ||
                  (mode_ff == MODE_RX8) || (mode_ff == MODE_RX4);
   wire is4 = mode_ff[1];
   wire tx_en = ~mode_ff[2] | (mode_ff == MODE_TRX8);
   wire rx_en = mode_ff[2];
   wire ext_sel = clksel_ff == CLK_EXT;
   wire fast_code = (clksel_ff != CLK_SLOWEST) && (clksel_ff <= CLK_FASTEST);
   wire clk_ok = (clksel_ff != CLK_RSVD) && !(slow_mode && fast_code);
   wire lf_sel = (clksel_ff == CLK_SLOWEST) && (tap_ff | slow_mode);
   wire [2:0] last_bit = is4 ? 3'h3 : 3'h7;
   // frame stretch only internal rx8 and trx8
   wire frame_en = (wait_ff != 2'h0) && !ext_sel && ((mode_ff == MODE_RX8) || (mode_ff == MODE_TRX8));
   wire [6:0] frame_len = 7'(((7'h01 << wait_ff) - 7'h01) * HALF_TICKS_PER_WORD8);
   wire fall_ev = ext_sel ? ext_fall : (half_tick & sck_ff);
   wire rise_ev = ext_sel ? ext_rise : (half_tick & ~sck_ff);

   assign so_o = so_ff;
   assign sck_o = sck_ff;
   assign sck_oe = ~ext_sel;
   assign transfer_irq = irq_ff;

   ssb_clkdiv u_div (
      .pclk(pclk),
      .presetn(presetn),
      .clear(state_ff == ST_IDLE),
      .clk_sel(clksel_ff),
      .lf_sel(lf_sel),
      .lf_clk(lf_clk),
      .half_tick(half_tick)
   );

   ssb_sck_edge u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .sck_i(sck_i),
      .fall(ext_fall),
      .rise(ext_rise)
   );

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_ff <= C1_RESET[C1_RUN_BIT];
         abort_ff <= C1_RESET[C1_ABORT_BIT];
         mode_ff <= C1_RESET[C1_MODE_LSB +: 3];
         clksel_ff <= C1_RESET[C1_CLK_LSB +: 3];
         cnt_ff <= C2_RESET[C2_CNT_LSB +: 3];
         wait_ff <= C2_RESET[C2_WAIT_LSB +: 2];
         tap_ff <= C2_RESET[C2_TAP_BIT];
         prdata_ff <= 32'h0000_0000;
      end else begin
         if (setup) prdata_ff <= rd_mux;
         if (wr_c1) begin
            run_ff <= pwdata[C1_RUN_BIT];
            mode_ff <= pwdata[C1_MODE_LSB +: 3];
            clksel_ff <= pwdata[C1_CLK_LSB +: 3];
         end
         abort_ff <= (wr_c1 & pwdata[C1_ABORT_BIT]) | (abort_ff & ~abort_done);
         if (wr_c2) begin
            cnt_ff <= pwdata[C2_CNT_LSB +: 3];
            wait_ff <= pwdata[C2_WAIT_LSB +: 2];
            tap_ff <= pwdata[C2_TAP_BIT];
         end
      end
   end

   // ----------------------------------------
   // Data buffer
   // ----------------------------------------
   // Receive store beats a bus write to the same entry
   for (genvar g = 0; g < BUF_DEPTH; g++) begin : g_buf
      wire wr_bus = wr & hit_buf & (buf_sel == 3'(g));
      wire wr_rx = rx_store & (word_ff == 3'(g));
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) buf_ff[g] <= BUF_RESET;
         else if (wr_rx) buf_ff[g] <= rx_word;
         else if (wr_bus) buf_ff[g] <= pwdata[7:0];
      end
   end

   // ----------------------------------------
   // Transfer engine
   // ----------------------------------------
   // lsb first, rx enters at the top
   assign rx_full = {si_i, rx_sh_ff[7:1]};
   // nibble modes zero the upper half
   assign rx_word = is4 ? {4'h0, rx_full[7:4]} : rx_full;

   always_comb begin
      nxt_state = state_ff;
      nxt_active = active_ff;
      nxt_word = word_ff;
      nxt_bit = bit_ff;
      nxt_sck = sck_ff;
      nxt_so = so_ff;
      nxt_tx_sh = tx_sh_ff;
      nxt_rx_sh = rx_sh_ff;
      nxt_frame = frame_ff;
      nxt_irq = 1'b0;
      abort_done = 1'b0;
      rx_store = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            nxt_sck = 1'b1;
            nxt_so = 1'b1;
            abort_done = abort_ff;
            if (run_ff && !abort_ff && mode_ok && clk_ok) begin
               nxt_state = ST_SHIFT;
               nxt_active = 1'b1;
               nxt_word = 3'h0;
               nxt_bit = 3'h0;
               nxt_tx_sh = buf_ff[0];
            end
         end
         ST_SHIFT: begin
            if (abort_ff) begin
               nxt_state = ST_IDLE;
               nxt_active = 1'b0;
               nxt_sck = 1'b1;
               nxt_so = 1'b1;
               abort_done = 1'b1;
            end else if (fall_ev) begin
               nxt_sck = 1'b0;
               nxt_so = tx_en ? tx_sh_ff[0] : 1'b1;
               nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
            end else if (rise_ev) begin
               nxt_sck = 1'b1;
               nxt_rx_sh = rx_full;
               nxt_bit = 3'(bit_ff + 3'h1);
               if (bit_ff == last_bit) begin
                  nxt_bit = 3'h0;
                  rx_store = rx_en;
                  if (word_ff == cnt_ff) begin
                     nxt_irq = 1'b1;
                     nxt_word = 3'h0;
                     nxt_tx_sh = buf_ff[0];
                     if (!run_ff) begin
                        nxt_state = ST_IDLE;
                        nxt_active = 1'b0;
                     end else if (frame_en) begin
                        nxt_state = ST_FRAME;
                        nxt_frame = frame_len;
                     end
                  end else begin
                     nxt_word = 3'(word_ff + 3'h1);
                     nxt_tx_sh = buf_ff[3'(word_ff + 3'h1)];
                     if (frame_en) begin
                        nxt_state = ST_FRAME;
                        nxt_frame = frame_len;
                     end
                  end
               end
            end
         end
         ST_FRAME: begin
            if (abort_ff) begin
               nxt_state = ST_IDLE;
               nxt_active = 1'b0;
               nxt_so = 1'b1;
               abort_done = 1'b1;
            end else if (half_tick) begin
               nxt_frame = 7'(frame_ff - 7'h01);
               if (frame_ff == 7'h01) nxt_state = ST_SHIFT;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
            nxt_active = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_IDLE;
         active_ff <= 1'b0;
         word_ff <= 3'h0;
         bit_ff <= 3'h0;
         sck_ff <= 1'b1;
         so_ff <= 1'b1;
         tx_sh_ff <= 8'h00;
         rx_sh_ff <= 8'h00;
         frame_ff <= 7'h00;
         irq_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         active_ff <= nxt_active;
         word_ff <= nxt_word;
         bit_ff <= nxt_bit;
         sck_ff <= nxt_sck;
         so_ff <= nxt_so;
         tx_sh_ff <= nxt_tx_sh;
         rx_sh_ff <= nxt_rx_sh;
         frame_ff <= nxt_frame;
         irq_ff <= nxt_irq;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_start;
      state_ff == ST_IDLE && run_ff && !abort_ff && mode_ok && clk_ok;
   endsequence
   sequence s_running;
      active_ff && state_ff == ST_SHIFT && word_ff == 3'h0 && bit_ff == 3'h0;
   endsequence

   property p_start;
      s_start |=> s_running;
   endproperty
   a_start: assert property (p_start) else $error("transfer did not start at entry zero");
   property p_abort_stop;
      (state_ff != ST_IDLE && abort_ff) |=> (!active_ff && state_ff == ST_IDLE && so_ff && sck_ff);
   endproperty
   a_abort_stop: assert property (p_abort_stop) else $error("abort did not stop transfer");
   property p_abort_clear;
      (abort_ff && !wr_c1) |=> !abort_ff;
   endproperty
   a_abort_clear: assert property (p_abort_clear) else $error("abort flag did not clear");
   property p_reserved;
      (state_ff == ST_IDLE && (!mode_ok || !clk_ok)) |=> (state_ff == ST_IDLE && so_ff && !active_ff);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved code started a transfer");
   property p_count_hold;
      !wr_c2 |=> $stable(cnt_ff);
   endproperty
   a_count_hold: assert property (p_count_hold) else $error("word count changed by hardware");
   property p_nibble;
      (rx_store && is4) |=> buf_ff[$past(word_ff)][7:4] == 4'h0;
   endproperty
   a_nibble: assert property (p_nibble) else $error("upper nibble not zero");
   property p_irq;
      irq_ff |-> ($past(word_ff) == cnt_ff && $past(bit_ff) == $past(last_bit));
   endproperty
   a_irq: assert property (p_irq) else $error("completion pulse before last word");
   property p_tx_edge;
      (active_ff && !ext_sel && $changed(so_ff) && $past(state_ff) == ST_SHIFT && !$past(abort_ff))
         |-> $fell(sck_ff);
   endproperty
   a_tx_edge: assert property (p_tx_edge) else $error("data changed off the falling edge");
   property p_lsb;
      (state_ff == ST_SHIFT && fall_ev && tx_en && !abort_ff) |=> so_ff == $past(tx_sh_ff[0]);
   endproperty
   a_lsb: assert property (p_lsb) else $error("transmit bit order wrong");
   property p_frame;
      (state_ff == ST_SHIFT && nxt_state == ST_FRAME)
         |=> (frame_ff == ((wait_ff == 2'h1) ? 7'h10 : (wait_ff == 2'h2) ? 7'h30 : 7'h70));
   endproperty
   a_frame: assert property (p_frame) else $error("frame wait length wrong");
   property p_shift_flag;
      (prdata_ff[ST_SHIFT_BIT] && $past(setup && hit_st)) |-> $past(state_ff) == ST_SHIFT;
   endproperty
   a_shift_flag: assert property (p_shift_flag) else $error("shift status wrong");
endmodule // ssb_top

// file: design/ssb_pkg.sv
// Constants for the buffered synchronous serial port.
// Assumes a single pclk domain and an APB register bus.
package ssb_pkg;
   // ----------------------------------------
   // Register indices (byte address = 4 * index)
   // ----------------------------------------
   localparam logic [11:0] IDX_BUF_BASE = 12'h0F90;
   localparam logic [11:0] IDX_CTRL1 = 12'h0F98;
   localparam logic [11:0] IDX_CTRL2 = 12'h0F99;
   localparam logic [11:0] IDX_STAT = 12'h0F9A;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int C1_RUN_BIT = 7;
   localparam int C1_ABORT_BIT = 6;
   localparam int C1_MODE_LSB = 3;
   localparam int C1_CLK_LSB = 0;
   localparam int C2_CNT_LSB = 0;
   localparam int C2_WAIT_LSB = 3;
   localparam int C2_TAP_BIT = 7;
   localparam int ST_ACTIVE_BIT = 7;
   localparam int ST_SHIFT_BIT = 6;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] C1_RESET = 8'h00;
   localparam logic [7:0] C2_RESET = 8'h00;
   localparam logic [7:0] BUF_RESET = 8'h00;
   // ----------------------------------------
   // Mode and clock codes
   // ----------------------------------------
   localparam logic [2:0] MODE_TX8 = 3'h0;
   localparam logic [2:0] MODE_TX4 = 3'h2;
   localparam logic [2:0] MODE_TRX8 = 3'h4;
   localparam logic [2:0] MODE_RX8 = 3'h5;
   localparam logic [2:0] MODE_RX4 = 3'h6;
   localparam logic [2:0] CLK_SLOWEST = 3'h0;
   localparam logic [2:0] CLK_FASTEST = 3'h5;
   localparam logic [2:0] CLK_RSVD = 3'h6;
   localparam logic [2:0] CLK_EXT = 3'h7;
   // ----------------------------------------
   // Divider exponents and counts
   // ----------------------------------------
   localparam logic [3:0] DIV_EXP_SLOWEST = 4'hD;
   localparam logic [3:0] DIV_EXP_OFFSET = 4'h9;
   localparam logic [3:0] LF_HALF_LAST = 4'hF;
   localparam logic [2:0] MIN_PULSE_CYC = 3'h4;
   localparam logic [6:0] HALF_TICKS_PER_WORD8 = 7'h10;
   localparam int BUF_DEPTH = 8;

   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_FRAME} ssb_state_t;
endpackage

// file: design/ssb_clkdiv.sv
// Serial clock divider: half-period ticks from pclk or the low-frequency clock.
// Assumes lf_clk is a level synchronous to pclk.
`timescale 1ns/1ps
module ssb_clkdiv
   import ssb_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clear,
   input wire logic [2:0] clk_sel,
   input wire logic lf_sel,
   input wire logic lf_clk,
   output logic half_tick
);
   logic [12:0] cnt_ff;
   logic [3:0] lf_cnt_ff;
   logic lf_q_ff;
   logic [3:0] div_exp;
   logic [12:0] mask;
   logic lf_rise;
   logic fc_tick;
   logic lf_tick;

   // ----------------------------------------
   // Tap selection
   // ----------------------------------------
   // fc taps
   assign div_exp = (clk_sel == CLK_SLOWEST) ? DIV_EXP_SLOWEST : 4'(DIV_EXP_OFFSET - {1'b0, clk_sel});
   assign mask = 13'((14'h0001 << (div_exp - 4'h1)) - 14'h0001);
   assign fc_tick = (cnt_ff & mask) == mask;
   assign lf_rise = lf_clk & ~lf_q_ff;
   assign lf_tick = lf_rise & (lf_cnt_ff == LF_HALF_LAST);
   assign half_tick = lf_sel ? lf_tick : fc_tick;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 13'h0000;
         lf_cnt_ff <= 4'h0;
         lf_q_ff <= 1'b0;
      end else begin
         lf_q_ff <= lf_clk;
         cnt_ff <= clear ? 13'h0000 : 13'(cnt_ff + 13'h0001);
         if (clear) lf_cnt_ff <= 4'h0;
         else if (lf_rise) lf_cnt_ff <= 4'(lf_cnt_ff + 4'h1);
      end
   end
endmodule // ssb_clkdiv

// file: design/ssb_sck_edge.sv
// Edge detector for an external serial clock with a minimum pulse filter.
// Assumes sck_i is synchronous to pclk; idle level is high.
`timescale 1ns/1ps
module ssb_sck_edge
   import ssb_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sck_i,
   output logic fall,
   output logic rise
);
   logic lvl_ff;
   logic [2:0] cnt_ff;
   logic flip;

   assign flip = (sck_i != lvl_ff) && (cnt_ff == 3'(MIN_PULSE_CYC - 3'h1));
   assign fall = flip & lvl_ff;
   assign rise = flip & ~lvl_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_ff <= 1'b1;
         cnt_ff <= 3'h0;
      end else begin
         if (flip) lvl_ff <= sck_i;
         cnt_ff <= (sck_i != lvl_ff && !flip) ? 3'(cnt_ff + 3'h1) : 3'h0;
      end
   end
endmodule // ssb_sck_edge

// file: test/ssb_peer.sv
// Behavioural serial peripheral facing the port.
// Assumes one pclk domain; the serial clock idles high.
`timescale 1ns/1ps
module ssb_peer (
   input wire logic pclk,
   input wire logic load,
   input wire logic ext_en,
   input wire logic sck_pin,
   input wire logic so_o,
   input wire logic [7:0] tx_byte,
   output logic sck_drv,
   output logic si_i,
   output logic [15:0] rx_sr,
   output logic [6:0] rx_cnt
);
   // ----
   // Shift logic
   // ----
   logic sck_q = 1'b1;
   logic [7:0] tx_sr = 8'h00;
   logic [3:0] div = 4'h0;
   logic [4:0] ext_n = 5'h10;
   initial begin
      sck_drv = 1'b1;
      si_i = 1'b1;
      rx_cnt = 7'h00;
   end
   always @(posedge pclk) begin
      sck_q <= sck_pin;
      if (load) begin
         tx_sr <= tx_byte;
         rx_cnt <= 7'h00;
         div <= 4'h0;
         ext_n <= ext_en ? 5'h00 : 5'h10;
      end else begin
         if (sck_q && !sck_pin) begin
            si_i <= tx_sr[0];
            tx_sr <= {~tx_sr[0], tx_sr[7:1]};
         end
         if (!sck_q && sck_pin) begin
            rx_sr <= {so_o, rx_sr[15:1]};
            rx_cnt <= rx_cnt + 7'h01;
         end
         if (ext_en && ext_n < 5'h10) begin
            div <= (div == 4'h9) ? 4'h0 : div + 4'h1;
            if (div == 4'h9) begin
               sck_drv <= ~sck_drv;
               ext_n <= ext_n + 5'h01;
            end
         end
      end
   end
endmodule // ssb_peer

// file: test/sync_serial_buffered_port_tb.sv
// Bench for the buffered serial port over APB.
// Assumes ssb_peer on the serial side and one pclk domain.
`timescale 1ns/1ps
module sync_serial_buffered_port_tb
   import ssb_pkg::*;
;
   // ----
   // Signals and tasks
   // ----
   localparam logic [15:0] A_BUF = {2'b00, IDX_BUF_BASE, 2'b00};
   localparam logic [15:0] A_C1 = {2'b00, IDX_CTRL1, 2'b00};
   localparam logic [15:0] A_C2 = {2'b00, IDX_CTRL2, 2'b00};
   localparam logic [15:0] A_ST = {2'b00, IDX_STAT, 2'b00};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic slow_mode = 1'b0;
   logic lf_clk = 1'b0;
   logic load = 1'b0;
   logic ext_en = 1'b0;
   logic sck_q = 1'b1;
   logic [1:0] lf_ph = 2'b00;
   logic pready, pslverr, si_i, so_o, sck_o, sck_oe, transfer_irq, sck_drv, re;
   logic [31:0] prdata, rq;
   logic [15:0] rx_sr;
   logic [6:0] rx_cnt;
   logic [2:0] md;
   logic [2:0] modes [5] = '{MODE_TX8, MODE_TX4, MODE_TRX8, MODE_RX8, MODE_RX4};
   int fails = 0, compares = 0, cyc = 0, irqs = 0, irq0, rises, r1, r9, nb;
   wire sck_pin = sck_oe ? sck_o : sck_drv;
   ssb_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .slow_mode(slow_mode), .lf_clk(lf_clk),
      .si_i(si_i), .so_o(so_o), .sck_i(sck_pin), .sck_o(sck_o), .sck_oe(sck_oe), .transfer_irq(transfer_irq));
   ssb_peer peer (.pclk(pclk), .load(load), .ext_en(ext_en), .sck_pin(sck_pin), .so_o(so_o), .tx_byte(8'hC3),
      .sck_drv(sck_drv), .si_i(si_i), .rx_sr(rx_sr), .rx_cnt(rx_cnt));
   initial begin
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      lf_ph <= lf_ph + 2'b01;
      lf_clk <= lf_ph[1];
      sck_q <= sck_pin;
      if (transfer_irq === 1'b1) irqs <= irqs + 1;
      if (load) rises <= 0;
      else if (sck_pin && !sck_q) begin
         rises <= rises + 1;
         if (rises == 0) r1 <= cyc;
         if (rises == 8) r9 <= cyc;
      end
      if (cyc == 40000) begin
         fails = fails + 1;
         wrap_up();
      end
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Request held until pready is sampled high
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [15:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   function automatic logic [31:0] c1(input logic [1:0] ra, input logic [2:0] m, input logic [2:0] k);
      return {24'h00_0000, ra, m, k};
   endfunction
   task automatic xfer(input logic [2:0] m, input logic [2:0] k, input logic [2:0] n, input logic [1:0] w,
      input logic tap, input logic wr2);
      // stop and abort in one plain write
      wr(A_C1, c1(2'b01, m, k));
      if (wr2) wr(A_C2, {24'h00_0000, tap, 2'b00, w, n});
      wr(A_C1, c1(2'b10, m, k));
      irq0 = irqs;
      load <= 1'b1;
      @(posedge pclk);
      load <= 1'b0;
      wr(A_C1, c1(2'b00, m, k));
      do rd(A_ST); while (rq[7] !== 1'b0);
   endtask
   task automatic wrap_up;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ----
   // Tests
   // ----
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(A_C1);
      chk("ctrl1 read", rq, 32'h0000_0000);
      rd(A_ST);
      chk("status idle", rq, 32'h0000_0000);
      chk("lines idle", {so_o, sck_o, sck_oe}, 3'b111);
      rd(16'h3E70);
      chk("unmapped err", re, 1'b1);
      $display("test reset done");
      for (int j = 0; j < 5; j++) begin
         md = modes[j];
         nb = (md[1:0] == 2'b10) ? 4 : 8;
         wr(A_BUF, 32'h0000_005A);
         xfer(md, CLK_FASTEST, 3'h0, 2'h0, 1'b0, 1'b1);
         chk("bits", rx_cnt, nb);
         chk("irq count", irqs - irq0, 1);
         rd(A_BUF);
         chk("buffer", rq, md[2] ? 8'hC3 & (8'hFF >> (8 - nb)) : 8'h5A);
         if (md != MODE_RX8 && md != MODE_RX4)
            chk("sent", rx_sr >> (16 - nb), 8'h5A & (8'hFF >> (8 - nb)));
      end
      $display("test modes done");
      wr(A_BUF, 32'h0000_00A5);
      wr(A_BUF + 16'h0004, 32'h0000_003C);
      for (int j = 0; j < 2; j++) begin
         xfer(MODE_TX8, CLK_FASTEST, 3'h1, 2'h0, 1'b0, j == 0);
         chk("two words", rx_sr, 16'h3CA5);
      end
      $display("test order done");
      wr(A_C2, 32'h0000_0007);
      wr(A_C1, c1(2'b10, MODE_TX8, CLK_FASTEST));
      repeat (20) @(posedge pclk);
      rd(A_ST);
      chk("busy", rq, 8'hC0);
      wr(A_C1, c1(2'b01, MODE_TX8, CLK_FASTEST));
      repeat (3) @(posedge pclk);
      rd(A_ST);
      chk("aborted", rq, 8'h00);
      $display("test abort done");
      for (int w = 0; w < 4; w++) begin
         xfer(MODE_TRX8, CLK_FASTEST, 3'h1, w[1:0], 1'b0, 1'b1);
         chk("frame time", r9 - r1, 128 << w);
      end
      $display("test wait done");
      for (int j = 0; j < 3; j++) begin
         slow_mode <= (j == 2);
         xfer(j == 1 ? 3'h1 : MODE_TX8, j == 0 ? CLK_RSVD : CLK_FASTEST, 3'h0, 2'h0, 1'b0, 1'b1);
         repeat (200) @(posedge pclk);
         chk("no start", rx_cnt, 0);
         chk("idle lines", {so_o, sck_o}, 2'b11);
      end
      $display("test refuse done");
      slow_mode <= 1'b0;
      for (int c = 1; c < 5; c++) begin
         xfer(MODE_TX8, 3'(c), 3'h1, 2'h0, 1'b0, 1'b1);
         chk("word time", r9 - r1, 4096 >> c);
      end
      for (int j = 0; j < 2; j++) begin
         slow_mode <= (j == 0);
         wr(A_BUF, 32'h0000_0096);
         xfer(MODE_TX8, CLK_SLOWEST, 3'h0, 2'h0, j == 1, 1'b1);
         chk("slow clock word", rx_sr[15:8], 8'h96);
      end
      slow_mode <= 1'b0;
      ext_en <= 1'b1;
      xfer(MODE_TX8, CLK_EXT, 3'h0, 2'h0, 1'b0, 1'b1);
      chk("pin released", sck_oe, 1'b0);
      chk("external word", rx_sr[15:8], 8'h96);
      $display("test clocks done");
      wrap_up();
   end
endmodule // sync_serial_buffered_port_tb
